// File: logic/spmpc_regs.svh
// Purpose: named constants of the spi master pin control block
// Assumes: included by bare name from the shifter, the top and the bench
// Notes: definitions only
`ifndef SPMPC_REGS_SVH
`define SPMPC_REGS_SVH

// ==========================================================
// timing
`define SPMPC_CLK_PERIOD_NS 40
// shortest legal low pulse on rstn, kept by the party outside [RQ7]
`define SPMPC_RST_MIN_NS 5000
`define SPMPC_RST_MIN_CYC ((`SPMPC_RST_MIN_NS + `SPMPC_CLK_PERIOD_NS - 1) / `SPMPC_CLK_PERIOD_NS)

// ==========================================================
// strap and pin levels
`define SPMPC_STRAP_SLOW 1'h0
`define SPMPC_STRAP_FAST 1'h1
`define SPMPC_CS_IDLE 1'h1
`define SPMPC_CS_ACTIVE 1'h0
`define SPMPC_SCLK_IDLE 1'h0

// ==========================================================
// shifter counts
`define SPMPC_BIT_FIRST 3'h0
`define SPMPC_BIT_LAST 3'h7
`define SPMPC_BIT_STEP 3'h1
`define SPMPC_PEND_NONE 3'h0
`define SPMPC_BYTE_ZERO 8'h00

`endif

// File: logic/spmpc_pkg.sv
// Purpose: types shared by the spi master pin control block
// Assumes: nothing from spmpc_regs.svh; enum codes are written out here
// Notes: state of each module is one packed struct
`default_nettype none
package spmpc_pkg;

  // ==========================================================
  // reference clock select code, latched at reset
  typedef enum logic [1:0] {
    SPMPC_REF_SEL0 = 2'h0,
    SPMPC_REF_SEL1 = 2'h1,
    SPMPC_REF_SEL2 = 2'h2,
    SPMPC_REF_SEL3 = 2'h3
  } spmpc_ref_t;

  // ==========================================================
  // link side shifter
  typedef enum logic [2:0] {
    SPMPC_ENG_IDLE = 3'h1,
    SPMPC_ENG_SHIFT = 3'h2,
    SPMPC_ENG_FLUSH = 3'h4
  } spmpc_eng_st_t;

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] en_s;
    logic [1:0] pd_s;
    logic [1:0] fast_s;
    logic [2:0] start_s;
    logic [1:0] miso_s;
    spmpc_eng_st_t st;
    logic div;
    logic sclk;
    logic cs_n;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [2:0] bitn;
    logic [2:0] pend;
    logic done_t;
    logic last;
  } spmpc_eng_t;

  // ==========================================================
  // system clock side control
  typedef struct packed {
    logic [1:0] strap_s;
    logic [1:0] rsel_a;
    logic [1:0] rsel_b;
    logic cap_done;
    logic strap_val;
    spmpc_ref_t ref_code;
    logic [2:0] done_s;
    logic [1:0] up_s;
    logic start_t;
    logic [7:0] tx;
    logic last;
    logic busy;
    logic [7:0] rx;
    logic rx_vld;
  } spmpc_ctl_t;

endpackage
`default_nettype wire

// File: logic/spmpc_link_if.sv
// Purpose: carrier between the control side and the link side shifter
// Assumes: levels and toggles only; every receiver synchronises
// Notes: tx and rx words stay still while their toggle is in flight
`timescale 1ns/1ps
`default_nettype none
interface spmpc_link_if;
  // control to link
  logic start_tog;
  logic [7:0] tx_byte;
  logic tx_last;
  logic fast;
  logic spi_on;
  logic powerdown;
  // link to control
  logic done_tog;
  logic [7:0] rx_byte;
  logic eng_up;

  modport ctrl (
    output start_tog, tx_byte, tx_last, fast, spi_on, powerdown,
    input done_tog, rx_byte, eng_up
  );
  modport eng (
    input start_tog, tx_byte, tx_last, fast, spi_on, powerdown,
    output done_tog, rx_byte, eng_up
  );
endinterface
`default_nettype wire

// File: logic/spmpc_shift_engine.sv
// Purpose: mode 0 byte shifter on the link clock
// Assumes: link_clk runs free; rstn arrives from the system clock domain
// Notes: sclk is link_clk/2 when fast, link_clk/4 when slow
`timescale 1ns/1ps
`default_nettype none
`include "spmpc_regs.svh"
module spmpc_shift_engine (
  // clock and reset
  input wire logic link_clk,
  input wire logic rstn,
  // control side
  spmpc_link_if.eng lk,
  // spi pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_serial_in
);
  import spmpc_pkg::*;

  spmpc_eng_t s_r;
  spmpc_eng_t s_nxt;
  logic abort;
  logic tick;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_s = {s_r.rst_s[0], rstn};
    s_nxt.en_s = {s_r.en_s[0], lk.spi_on};
    s_nxt.pd_s = {s_r.pd_s[0], lk.powerdown};
    s_nxt.fast_s = {s_r.fast_s[0], lk.fast};
    s_nxt.start_s = {s_r.start_s[1:0], lk.start_tog};
    s_nxt.miso_s = {s_r.miso_s[0], spi_serial_in};
    s_nxt.pend = {s_r.pend[1:0], 1'b0};
    abort = !s_r.en_s[1] || s_r.pd_s[1];
    tick = s_r.fast_s[1] || s_r.div; // RQ3
    // input pin waits two flops, so the sample lags the rising edge
    if (s_r.pend[2] && s_r.cs_n == `SPMPC_CS_ACTIVE) begin
      s_nxt.rx = {s_r.rx[6:0], s_r.miso_s[1]}; // RQ9
    end
    unique case (s_r.st)
      SPMPC_ENG_IDLE: begin
        if (abort) begin
          s_nxt.cs_n = `SPMPC_CS_IDLE; // RQ2
        end
        if (s_r.start_s[2] != s_r.start_s[1]) begin
          if (abort) begin
            s_nxt.done_t = !s_r.done_t;
          end else begin
            s_nxt.sh = lk.tx_byte;
            s_nxt.last = lk.tx_last;
            s_nxt.cs_n = `SPMPC_CS_ACTIVE; // RQ1
            s_nxt.bitn = `SPMPC_BIT_FIRST;
            s_nxt.div = 1'b0;
            s_nxt.st = SPMPC_ENG_SHIFT;
          end
        end
      end
      SPMPC_ENG_SHIFT: begin
        if (abort) begin
          // powerdown wins mid byte; the answer still returns
          s_nxt.cs_n = `SPMPC_CS_IDLE; // RQ2
          s_nxt.sclk = `SPMPC_SCLK_IDLE;
          s_nxt.done_t = !s_r.done_t;
          s_nxt.st = SPMPC_ENG_IDLE;
        end else begin
          s_nxt.div = !s_r.div;
          if (tick) begin
            s_nxt.sclk = !s_r.sclk; // RQ9
            if (!s_r.sclk) begin
              s_nxt.pend[0] = 1'b1;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.bitn = s_r.bitn + `SPMPC_BIT_STEP;
              if (s_r.bitn == `SPMPC_BIT_LAST) begin
                s_nxt.st = SPMPC_ENG_FLUSH;
              end
            end
          end
        end
      end
      SPMPC_ENG_FLUSH: begin
        if (s_r.pend == `SPMPC_PEND_NONE) begin
          s_nxt.done_t = !s_r.done_t;
          if (s_r.last || abort) begin
            s_nxt.cs_n = `SPMPC_CS_IDLE; // RQ1
          end
          s_nxt.st = SPMPC_ENG_IDLE;
        end
      end
    endcase
    if (!s_r.rst_s[1]) begin
      s_nxt.st = SPMPC_ENG_IDLE;
      s_nxt.div = 1'b0;
      s_nxt.sclk = `SPMPC_SCLK_IDLE;
      s_nxt.cs_n = `SPMPC_CS_IDLE; // RQ6
      s_nxt.sh = `SPMPC_BYTE_ZERO;
      s_nxt.rx = `SPMPC_BYTE_ZERO;
      s_nxt.bitn = `SPMPC_BIT_FIRST;
      s_nxt.pend = `SPMPC_PEND_NONE;
      s_nxt.done_t = 1'b0;
      s_nxt.last = 1'b0;
      s_nxt.start_s = 3'h0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge link_clk) begin
    s_r <= s_nxt;
  end

  assign spi_cs_n = s_r.cs_n;
  assign spi_sclk = s_r.sclk;
  assign spi_mosi = s_r.sh[7];
  assign lk.done_tog = s_r.done_t;
  assign lk.rx_byte = s_r.rx;
  assign lk.eng_up = s_r.rst_s[1];
endmodule // spmpc_shift_engine
`default_nettype wire

// File: logic/spmpc_top.sv
// Purpose: spi master port with rate strap, reference select and reset
// Assumes: clock is the system clock; link_clk feeds the spi shifter
// Notes: one byte per request; cs stays low until a byte marked last, or until powerdown or disable aborts
`timescale 1ns/1ps
`default_nettype none
`include "spmpc_regs.svh"
// Function
// [RQ1] chip select low only during selected transfers
// [RQ2] chip select high throughout powerdown when enabled
// [RQ3] strap picks spi rate: 0 slow, 1 fast
// [RQ4] strap latched 1: pin floats in suspend
// [RQ5] strap latched 0: pin driven low in suspend
// [RQ6] held in reset while rstn low
// [RQ7] outside reset pulse at least five microseconds
// [RQ8] reference frequency taken from two select inputs
// [RQ9] mode 0 master; sample input only when selected
module spmpc_top (
  // clocks and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clk,
  // byte requests
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [7:0] xfer_data,
  input wire logic xfer_last,
  output logic rx_valid,
  output logic [7:0] rx_data,
  // mode and status
  input wire logic spi_enable,
  input wire logic powerdown,
  input wire logic suspend,
  output logic device_ready,
  output logic spi_fast,
  output spmpc_pkg::spmpc_ref_t ref_freq_code,
  // reference select pins
  input wire logic ref_freq_select_bit0,
  input wire logic ref_freq_select_bit1,
  // rate strap pin
  input wire logic spi_rate_strap_in,
  output logic spi_rate_strap_out,
  output logic spi_rate_strap_oe,
  // spi pins
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_serial_in
);
  import spmpc_pkg::*;

  spmpc_ctl_t c_r;
  spmpc_ctl_t c_nxt;
  logic accept;
  logic done_edge;

  spmpc_link_if lk ();

  // ==========================================================
  // link side shifter
  spmpc_shift_engine u_engine (
    .link_clk(link_clk),
    .rstn(rstn),
    .lk(lk),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .spi_serial_in(spi_serial_in)
  );

  // ==========================================================
  // handshake
  assign device_ready = c_r.cap_done && c_r.up_s[1]; // RQ6
  // no new byte while powered down, so only a byte already taken can be cut short by an abort
  assign xfer_ready = device_ready && !c_r.busy && spi_enable && !powerdown;
  assign accept = xfer_valid && xfer_ready;
  assign done_edge = c_r.done_s[2] != c_r.done_s[1];

  // ==========================================================
  // next state
  always_comb begin
    c_nxt = c_r;
    c_nxt.strap_s = {c_r.strap_s[0], spi_rate_strap_in};
    c_nxt.rsel_a = {ref_freq_select_bit1, ref_freq_select_bit0};
    c_nxt.rsel_b = c_r.rsel_a;
    c_nxt.done_s = {c_r.done_s[1:0], lk.done_tog};
    c_nxt.up_s = {c_r.up_s[0], lk.eng_up};
    c_nxt.rx_vld = 1'b0;
    // straps are read in the first cycle after release
    if (!c_r.cap_done) begin
      c_nxt.strap_val = c_r.strap_s[1]; // RQ4
      c_nxt.ref_code = spmpc_ref_t'(c_r.rsel_b); // RQ8
      c_nxt.cap_done = 1'b1;
    end
    if (accept) begin
      c_nxt.tx = xfer_data;
      c_nxt.last = xfer_last;
      c_nxt.start_t = !c_r.start_t;
      c_nxt.busy = 1'b1;
    end
    if (done_edge) begin
      c_nxt.rx = lk.rx_byte;
      c_nxt.rx_vld = 1'b1;
      c_nxt.busy = 1'b0;
    end
    if (!rstn) begin
      c_nxt.cap_done = 1'b0; // RQ6
      c_nxt.strap_val = `SPMPC_STRAP_SLOW;
      c_nxt.ref_code = SPMPC_REF_SEL0;
      c_nxt.start_t = 1'b0;
      c_nxt.tx = `SPMPC_BYTE_ZERO;
      c_nxt.last = 1'b0;
      c_nxt.busy = 1'b0;
      c_nxt.rx = `SPMPC_BYTE_ZERO;
      c_nxt.rx_vld = 1'b0;
      c_nxt.done_s = 3'h0;
      c_nxt.up_s = 2'h0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock) begin
    c_r <= c_nxt;
  end

  // ==========================================================
  // outputs and link wires
  assign rx_valid = c_r.rx_vld;
  assign rx_data = c_r.rx;
  assign spi_fast = c_r.strap_val == `SPMPC_STRAP_FAST; // RQ3
  assign ref_freq_code = c_r.ref_code; // RQ8
  assign spi_rate_strap_out = 1'b0; // RQ5
  assign spi_rate_strap_oe = suspend && c_r.cap_done && (c_r.strap_val == `SPMPC_STRAP_SLOW); // RQ5
  assign lk.start_tog = c_r.start_t;
  assign lk.tx_byte = c_r.tx;
  assign lk.tx_last = c_r.last;
  assign lk.fast = spi_fast;
  assign lk.spi_on = spi_enable;
  assign lk.powerdown = powerdown; // RQ2
endmodule // spmpc_top
`default_nettype wire

// File: test/spmpc_slave_model.sv
// Purpose: behavioural spi slave facing spmpc_top
// Assumes: mode 0; one fixed reply byte per byte slot
// Notes: released data line sits at its pull-down level
`timescale 1ns/1ps
`default_nettype none
module spmpc_slave_model #(
  parameter logic [7:0] REPLY = 8'h5a
) (
  // spi pins
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_serial_in,
  // bench side
  output logic [7:0] got
);
  logic [7:0] sh = 8'h00;
  logic [2:0] cnt = 3'h0;
  // ==========================================================
  // shifter
  always @(posedge spi_sclk) got <= {got[6:0], spi_mosi};
  // reload at frame end or after each eighth fall, so bytes of one frame repeat
  always @(posedge spi_cs_n or negedge spi_sclk) begin
    sh <= (spi_cs_n || cnt == 3'h7) ? REPLY : {sh[6:0], 1'b0};
    cnt <= spi_cs_n ? 3'h0 : cnt + 3'h1;
  end
  // not selected: no drive, pull-down wins
  assign spi_serial_in = spi_cs_n ? 1'b0 : sh[7];
endmodule // spmpc_slave_model
`default_nettype wire

// File: test/spmpc_top_asserts.sv
// Purpose: port checks for spmpc_top
// Assumes: strap and select pins steady through reset
// Notes: bound at the foot
`timescale 1ns/1ps
`default_nettype none
module spmpc_top_asserts (
  // clocks and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic link_clk,
  // status
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic rx_valid,
  input wire logic spi_enable,
  input wire logic powerdown,
  input wire logic suspend,
  input wire logic device_ready,
  input wire logic spi_fast,
  input wire spmpc_pkg::spmpc_ref_t ref_freq_code,
  // pins
  input wire logic ref_freq_select_bit0,
  input wire logic ref_freq_select_bit1,
  input wire logic spi_rate_strap_out,
  input wire logic spi_rate_strap_oe,
  input wire logic spi_cs_n,
  input wire logic spi_sclk
);
  import spmpc_pkg::*;
  // ==========================================================
  // system clock side
  sequence s_take; xfer_valid && xfer_ready; endsequence
  property p_answer; @(posedge clock) disable iff (!rstn) s_take |-> ##[1:200] rx_valid; endproperty
  a_answer: assert property (p_answer) else $error("byte never answered");
  // reset is the cause here, so it cannot also disable the check
  property p_reset; @(posedge clock) !rstn |=> !device_ready && !xfer_ready && !rx_valid; endproperty
  a_reset: assert property (p_reset) else $error("active while reset low");
  property p_ref; @(posedge clock) disable iff (!rstn)
    $rose(device_ready) |-> ref_freq_code == {ref_freq_select_bit1, ref_freq_select_bit0}; endproperty
  a_ref: assert property (p_ref) else $error("reference code differs from pins");
  property p_strap_low; @(posedge clock) disable iff (!rstn)
    suspend && $stable(suspend) && device_ready && !spi_fast |-> spi_rate_strap_oe && !spi_rate_strap_out; endproperty
  a_strap_low: assert property (p_strap_low) else $error("strap pin not driven low");
  property p_strap_rel; @(posedge clock) disable iff (!rstn)
    (spi_fast || !suspend) && $stable(suspend) && device_ready |-> !spi_rate_strap_oe; endproperty
  a_strap_rel: assert property (p_strap_rel) else $error("strap pin driven");
  // ==========================================================
  // link side
  property p_fast; @(posedge link_clk) disable iff (!rstn) spi_fast && $rose(spi_sclk) |=> !spi_sclk; endproperty
  a_fast: assert property (p_fast) else $error("fast clock too slow");
  property p_slow; @(posedge link_clk) disable iff (!rstn)
    !spi_fast && $rose(spi_sclk) |=> (spi_sclk || spi_cs_n) ##1 !spi_sclk; endproperty
  a_slow: assert property (p_slow) else $error("slow clock wrong rate");
  property p_sel; @(posedge link_clk) disable iff (!rstn) $rose(spi_sclk) |-> !spi_cs_n; endproperty
  a_sel: assert property (p_sel) else $error("clock edge without select");
  property p_pd; @(posedge link_clk) disable iff (!rstn) (powerdown && spi_enable)[*5] |-> spi_cs_n; endproperty
  a_pd: assert property (p_pd) else $error("select low in powerdown");
endmodule // spmpc_top_asserts
bind spmpc_top spmpc_top_asserts chk_u (.clock(clock), .rstn(rstn), .link_clk(link_clk),
  .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .rx_valid(rx_valid), .spi_enable(spi_enable),
  .powerdown(powerdown), .suspend(suspend), .device_ready(device_ready), .spi_fast(spi_fast),
  .ref_freq_code(ref_freq_code), .ref_freq_select_bit0(ref_freq_select_bit0),
  .ref_freq_select_bit1(ref_freq_select_bit1), .spi_rate_strap_out(spi_rate_strap_out),
  .spi_rate_strap_oe(spi_rate_strap_oe), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk));
`default_nettype wire

// File: test/spi_master_pin_control_tb_top.sv
// Purpose: directed bench for spmpc_top
// Assumes: slave answers 8'h5a in every byte slot
// Notes: inputs move 2 ns after the rising clock edge
`timescale 1ns/1ps
`default_nettype none
`include "spmpc_regs.svh"
module spi_master_pin_control_tb_top;
  import spmpc_pkg::*;
  logic clock, rstn, link_clk, xfer_valid, xfer_last, spi_enable, powerdown, suspend, strap_val;
  logic ref_freq_select_bit0, ref_freq_select_bit1;
  logic [7:0] xfer_data;
  wire logic xfer_ready, rx_valid, device_ready, spi_fast, spi_rate_strap_out, spi_rate_strap_oe;
  wire logic spi_rate_strap_in, spi_cs_n, spi_sclk, spi_mosi, spi_serial_in;
  wire logic [7:0] rx_data, got;
  wire spmpc_ref_t ref_freq_code;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // strap pin: device drive wins, else the board strap level
  assign spi_rate_strap_in = spi_rate_strap_oe ? spi_rate_strap_out : strap_val;
  spmpc_top dut_u (.clock(clock), .rstn(rstn), .link_clk(link_clk), .xfer_valid(xfer_valid),
    .xfer_ready(xfer_ready), .xfer_data(xfer_data), .xfer_last(xfer_last), .rx_valid(rx_valid),
    .rx_data(rx_data), .spi_enable(spi_enable), .powerdown(powerdown), .suspend(suspend),
    .device_ready(device_ready), .spi_fast(spi_fast), .ref_freq_code(ref_freq_code),
    .ref_freq_select_bit0(ref_freq_select_bit0), .ref_freq_select_bit1(ref_freq_select_bit1),
    .spi_rate_strap_in(spi_rate_strap_in), .spi_rate_strap_out(spi_rate_strap_out),
    .spi_rate_strap_oe(spi_rate_strap_oe), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_serial_in(spi_serial_in));
  spmpc_slave_model slave_u (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_serial_in(spi_serial_in), .got(got));
  // ==========================================================
  // clocks and timeout
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  // ==========================================================
  // tasks
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // which output wait_for watches; nets cannot be passed by reference
  localparam int sel_dev = 0;
  localparam int sel_rdy = 1;
  localparam int sel_rx = 2;
  function automatic logic pick(input int w);
    return (w == sel_dev) ? device_ready : (w == sel_rdy) ? xfer_ready : rx_valid;
  endfunction
  task automatic wait_for(input int w);
    int i;
    i = 0;
    while (pick(w) !== 1'b1 && i < 200) begin
      @(posedge clock);
      #2;
      i++;
    end
    chk(pick(w) === 1'b1, "wait ran out");
  endtask
  task automatic do_reset(input logic s, input logic [1:0] sel);
    @(posedge clock);
    #2 {rstn, strap_val, ref_freq_select_bit1, ref_freq_select_bit0} = {1'b0, s, sel};
    repeat (`SPMPC_RST_MIN_CYC) @(posedge clock);
    #2 chk(device_ready === 1'b0 && rx_valid === 1'b0 && spi_cs_n === 1'b1, "active in reset");
    rstn = 1'b1;
    wait_for(sel_dev);
  endtask
  task automatic start(input logic [7:0] d, input logic last);
    wait_for(sel_rdy);
    {xfer_valid, xfer_data, xfer_last} = {1'b1, d, last};
    @(posedge clock);
    #2 xfer_valid = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last);
    start(d, last);
    wait_for(sel_rx);
    chk(rx_data === 8'h5a && got === d, "byte content");
  endtask
  // ==========================================================
  // tests
  initial begin
    {rstn, xfer_valid, xfer_data, xfer_last, powerdown, suspend, strap_val} = '0;
    {spi_enable, ref_freq_select_bit1, ref_freq_select_bit0} = 3'b100;
    do_reset(1'b1, 2'h2);
    chk(spi_fast === 1'b1 && ref_freq_code === SPMPC_REF_SEL2, "fast strap");
    xfer(8'ha5, 1'b0);
    chk(spi_cs_n === 1'b0, "select dropped inside frame");
    xfer(8'h3c, 1'b1);
    chk(spi_cs_n === 1'b1, "select held after frame");
    suspend = 1'b1;
    repeat (3) @(posedge clock);
    #2 chk(spi_rate_strap_oe === 1'b0 && spi_rate_strap_in === 1'b1, "strap pin driven");
    do_reset(1'b0, 2'h1);
    chk(spi_fast === 1'b0 && ref_freq_code === SPMPC_REF_SEL1, "slow strap");
    repeat (3) @(posedge clock);
    #2 chk(spi_rate_strap_oe === 1'b1 && spi_rate_strap_in === 1'b0, "strap pin free");
    suspend = 1'b0;
    xfer(8'h81, 1'b1);
    // abort mid byte: still answered, select released
    start(8'hff, 1'b1);
    repeat (20) @(posedge clock);
    #2 powerdown = 1'b1;
    wait_for(sel_rx);
    chk(spi_cs_n === 1'b1 && xfer_ready === 1'b0, "powerdown select");
    @(posedge clock);
    #2 {powerdown, spi_enable} = 2'b00;
    repeat (2) @(posedge clock);
    #2 chk(xfer_ready === 1'b0 && spi_cs_n === 1'b1, "ready while disabled");
    spi_enable = 1'b1;
    xfer(8'h0f, 1'b1);
    test_done();
  end
endmodule // spi_master_pin_control_tb_top
`default_nettype wire
